/* File: common/dcps_pkg.sv */
package dcps_pkg;

    // decoded command seen at a clock edge
    typedef enum logic [3:0] {
        DCPS_CMD_DESEL,
        DCPS_CMD_NOP,
        DCPS_CMD_MRS,
        DCPS_CMD_REF,
        DCPS_CMD_PRE,
        DCPS_CMD_ACT,
        DCPS_CMD_WR,
        DCPS_CMD_RD,
        DCPS_CMD_ZQ
    } dcps_cmd_t;

    // power state reported to the core
    typedef enum logic [2:0] {
        DCPS_PS_IDLE,
        DCPS_PS_ACTIVE,
        DCPS_PS_PRE_PD,
        DCPS_PS_ACT_PD,
        DCPS_PS_SELF_REF
    } dcps_ps_t;

    localparam int DCPS_NBANK = 8;
    localparam logic [DCPS_NBANK-1:0] DCPS_BANKS_CLOSED = 8'h00;
    localparam logic [2:0] DCPS_PS_W = 3'h0;

endpackage

/* File: design/dcps_cke_power_state.sv */
// How it works
// - cke is registered every edge; decisions use previous cke, current cke, command.
// - decisions use the state held just before the edge.
// - only nop or deselect on power-down entry and exit edges; else illegal.
// - power-down entry goes precharge if all banks closed, otherwise active.
// - with cke low in power-down or self refresh, command pins are ignored.
// - no internal refresh while powered down.
// - self refresh entered by refresh on cke fall from idle or active; flagged illegal unless idle.
// - termination off during self refresh; odt pin ignored by power states.
// - idle means banks closed, no burst, cke high, all timings met.
// - idle or active with cke held low is flagged illegal; other unlisted combinations are not.
// - self-refresh exit seen from cke level, not from a cke rise.
// - deselect is treated exactly like nop.
`timescale 1ns/1ns
module dcps_cke_power_state (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic reset_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] bank_addr,
    input wire logic odt,
    input wire logic burst_busy,
    input wire logic timing_busy,
    output logic [2:0] power_state,
    output logic array_refresh_en,
    output logic odt_active,
    output logic illegal_cmd,
    output logic idle
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic cke_s1;
    logic cke_s2;
    logic cke_prev;
    logic rst_n_s1;
    logic rst_n_s2;
    logic [3:0] cmd_s1;
    logic [3:0] cmd_s2;
    logic [2:0] ba_s1;
    logic [2:0] ba_s2;
    logic odt_s1;
    logic odt_s2;

    always_ff @(posedge sys_clk) begin
        cke_s1 <= cke;
        cke_s2 <= cke_s1;
        rst_n_s1 <= reset_n;
        rst_n_s2 <= rst_n_s1;
        cmd_s1 <= {cs_n, ras_n, cas_n, we_n};
        cmd_s2 <= cmd_s1;
        ba_s1 <= bank_addr;
        ba_s2 <= ba_s1;
        odt_s1 <= odt;
        odt_s2 <= odt_s1;
    end

    ////////////////////////////////////////////////////////////////////////
    // command decode
    function automatic dcps_pkg::dcps_cmd_t dcps_decode(input logic [3:0] pins);
        dcps_pkg::dcps_cmd_t c;
        c = dcps_pkg::DCPS_CMD_DESEL;
        if (!pins[3]) begin
            unique case (pins[2:0])
                3'h7: c = dcps_pkg::DCPS_CMD_NOP;
                3'h0: c = dcps_pkg::DCPS_CMD_MRS;
                3'h1: c = dcps_pkg::DCPS_CMD_REF;
                3'h2: c = dcps_pkg::DCPS_CMD_PRE;
                3'h3: c = dcps_pkg::DCPS_CMD_ACT;
                3'h4: c = dcps_pkg::DCPS_CMD_WR;
                3'h5: c = dcps_pkg::DCPS_CMD_RD;
                3'h6: c = dcps_pkg::DCPS_CMD_ZQ;
            endcase
        end
        return c;
    endfunction

    dcps_pkg::dcps_cmd_t cmd;
    dcps_pkg::dcps_ps_t state;
    dcps_pkg::dcps_ps_t next_state;
    logic [dcps_pkg::DCPS_NBANK-1:0] open_banks;
    logic [dcps_pkg::DCPS_NBANK-1:0] next_open_banks;
    logic next_illegal;
    wire logic quiet_cmd;
    wire logic cke_fall;
    wire logic cke_rise;
    wire logic banks_closed;
    wire logic powered_down;

    assign cmd = dcps_decode(cmd_s2);
    assign quiet_cmd = (cmd == dcps_pkg::DCPS_CMD_NOP) || (cmd == dcps_pkg::DCPS_CMD_DESEL);
    // edge from previous and current cke
    assign cke_fall = cke_prev && !cke_s2;
    assign cke_rise = !cke_prev && cke_s2;
    assign banks_closed = (next_open_banks == dcps_pkg::DCPS_BANKS_CLOSED);
    assign powered_down = (state == dcps_pkg::DCPS_PS_PRE_PD)
        || (state == dcps_pkg::DCPS_PS_ACT_PD);

    ////////////////////////////////////////////////////////////////////////
    // bank tracking for the next edge
    always_comb begin
        next_open_banks = open_banks;
        if (cke_prev && cke_s2) begin
            unique case (cmd)
                dcps_pkg::DCPS_CMD_ACT: next_open_banks[ba_s2] = 1'b1;
                dcps_pkg::DCPS_CMD_PRE: next_open_banks = dcps_pkg::DCPS_BANKS_CLOSED;
                default: next_open_banks = open_banks;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power state decision
    always_comb begin
        next_state = state;
        next_illegal = 1'b0;
        // case on state held before edge
        unique case (state)
            dcps_pkg::DCPS_PS_PRE_PD, dcps_pkg::DCPS_PS_ACT_PD: begin
                if (cke_rise) begin
                    next_illegal = !quiet_cmd;
                    next_state = (open_banks == dcps_pkg::DCPS_BANKS_CLOSED)
                        ? dcps_pkg::DCPS_PS_IDLE : dcps_pkg::DCPS_PS_ACTIVE;
                end
            end
            dcps_pkg::DCPS_PS_SELF_REF: begin
                if (cke_s2) begin
                    next_state = dcps_pkg::DCPS_PS_IDLE;
                end
            end
            default: begin
                if (cke_fall) begin
                    if (cmd == dcps_pkg::DCPS_CMD_REF) begin
                        next_illegal = (state != dcps_pkg::DCPS_PS_IDLE) || !idle;
                        next_state = dcps_pkg::DCPS_PS_SELF_REF;
                    end else begin
                        next_illegal = !quiet_cmd;
                        next_state = banks_closed ? dcps_pkg::DCPS_PS_PRE_PD
                            : dcps_pkg::DCPS_PS_ACT_PD;
                    end
                end else if (cke_s2) begin
                    next_state = banks_closed ? dcps_pkg::DCPS_PS_IDLE
                        : dcps_pkg::DCPS_PS_ACTIVE;
                end else begin
                    next_illegal = 1'b1;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state registers and outputs
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !rst_n_s2) begin
            cke_prev <= 1'b0;
            state <= dcps_pkg::DCPS_PS_IDLE;
            open_banks <= dcps_pkg::DCPS_BANKS_CLOSED;
            power_state <= dcps_pkg::DCPS_PS_W;
            array_refresh_en <= 1'b0;
            odt_active <= 1'b0;
            illegal_cmd <= 1'b0;
            idle <= 1'b0;
        end else begin
            cke_prev <= cke_s2;
            state <= next_state;
            open_banks <= (next_state == dcps_pkg::DCPS_PS_SELF_REF)
                ? dcps_pkg::DCPS_BANKS_CLOSED : next_open_banks;
            power_state <= next_state;
            array_refresh_en <= (next_state == dcps_pkg::DCPS_PS_SELF_REF);
            odt_active <= odt_s2 && (next_state != dcps_pkg::DCPS_PS_SELF_REF);
            illegal_cmd <= next_illegal;
            idle <= (next_state == dcps_pkg::DCPS_PS_IDLE) && banks_closed
                && !burst_busy && !timing_busy && cke_s2;
        end
    end

endmodule // dcps_cke_power_state

/* File: dv/dcps_cke_power_state_props.sv */
`timescale 1ns/1ns
module dcps_cke_power_state_props (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic reset_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] bank_addr,
    input wire logic odt,
    input wire logic burst_busy,
    input wire logic timing_busy,
    input wire logic [2:0] power_state,
    input wire logic array_refresh_en,
    input wire logic odt_active,
    input wire logic illegal_cmd,
    input wire logic idle
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst || !reset_n);
    // pins reach the decision two edges late
    sequence s_fall; $past(cke, 3) && !$past(cke, 2); endsequence
    sequence s_rise; !$past(cke, 3) && $past(cke, 2); endsequence
    sequence s_nop; $past(cs_n, 2) || $past({ras_n, cas_n, we_n}, 2) == 3'h7; endsequence
    sequence s_ref; $past({cs_n, ras_n, cas_n, we_n}, 2) == 4'h1; endsequence
    a_pd_entry: assert property (power_state == 3'h0 ##0 s_fall ##0 s_nop
        |=> power_state == 3'h2) else $error("no precharge power down");
    a_sr_entry: assert property (power_state == 3'h0 ##0 s_fall ##0 s_ref
        |=> power_state == 3'h4) else $error("no self refresh entry");
    a_sr_from_idle: assert property (power_state == 3'h4 && $past(power_state) != 3'h4
        |-> $past(power_state) == 3'h0) else $error("self refresh not from idle");
    a_pd_exit: assert property (power_state inside {3'h2, 3'h3} ##0 s_rise ##0 s_nop
        |=> power_state inside {3'h0, 3'h1}) else $error("no power down exit");
    a_low_hold: assert property (power_state inside {3'h2, 3'h3, 3'h4}
        && !$past(cke, 2) && !$past(cke, 3) |=> $stable(power_state)) else $error("state left");
    a_bad_entry: assert property (power_state == 3'h0 ##0 s_fall ##0 (!$past(cs_n, 2)
        && !($past({ras_n, cas_n, we_n}, 2) inside {3'h7, 3'h1})) |=> illegal_cmd)
        else $error("illegal entry not flagged");
    a_refresh_sr: assert property (array_refresh_en == (power_state == 3'h4))
        else $error("array refresh outside self refresh");
    a_odt_sr: assert property (power_state == 3'h4 && $past(power_state) == 3'h4
        |-> !odt_active) else $error("termination in self refresh");
    a_idle_cause: assert property (idle
        |-> power_state == 3'h0 && !$past(burst_busy)) else $error("idle while busy");
endmodule // dcps_cke_power_state_props
bind dcps_cke_power_state dcps_cke_power_state_props i_dcps_cke_power_state_props (.*);

/* File: dv/dcps_ctl_model.sv */
`timescale 1ns/1ns
module dcps_ctl_model (
    input wire logic sys_clk,
    input wire logic cke_req,
    input wire dcps_pkg::dcps_cmd_t cmd_req,
    output logic cke = 1'b1,
    output logic cs_n = 1'b1,
    output logic ras_n = 1'b1,
    output logic cas_n = 1'b1,
    output logic we_n = 1'b1
);
    // requested levels held as long as asked; deselect toggles ras_n, cas_n, we_n each cycle
    always @(negedge sys_clk) begin
        #1;
        cke <= cke_req;
        cs_n <= (cmd_req == dcps_pkg::DCPS_CMD_DESEL);
        case (cmd_req)
            dcps_pkg::DCPS_CMD_MRS: {ras_n, cas_n, we_n} <= 3'h0;
            dcps_pkg::DCPS_CMD_REF: {ras_n, cas_n, we_n} <= 3'h1;
            dcps_pkg::DCPS_CMD_PRE: {ras_n, cas_n, we_n} <= 3'h2;
            dcps_pkg::DCPS_CMD_ACT: {ras_n, cas_n, we_n} <= 3'h3;
            dcps_pkg::DCPS_CMD_WR: {ras_n, cas_n, we_n} <= 3'h4;
            dcps_pkg::DCPS_CMD_RD: {ras_n, cas_n, we_n} <= 3'h5;
            dcps_pkg::DCPS_CMD_ZQ: {ras_n, cas_n, we_n} <= 3'h6;
            dcps_pkg::DCPS_CMD_NOP: {ras_n, cas_n, we_n} <= 3'h7;
            default: {ras_n, cas_n, we_n} <= ~{ras_n, cas_n, we_n};
        endcase
    end
endmodule // dcps_ctl_model

/* File: dv/dcps_cke_power_state_bench.sv */
`timescale 1ns/1ns
module dcps_cke_power_state_bench;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reset_n = 1'b1;
    logic odt = 1'b1;
    logic burst_busy = 1'b0;
    logic timing_busy = 1'b0;
    logic [2:0] bank_addr = 3'h0;
    logic cke_req = 1'b1;
    dcps_pkg::dcps_cmd_t cmd_req = dcps_pkg::DCPS_CMD_NOP;
    logic cke, cs_n, ras_n, cas_n, we_n, array_refresh_en, odt_active, illegal_cmd, idle, seen;
    logic [2:0] power_state, exp_ps;
    int failures = 0;
    int check_count = 0;
    // cke drops only on nop or refresh rows
    // no read or write after exit
    // row: cke level, command code, expected power state
    logic [7:0] rows [14] = '{8'h90, 8'hc0, 8'h88, 8'h0a, 8'h2a, 8'h80, 8'ha9, 8'h0b, 8'h3b,
        8'h89, 8'ha0, 8'h1c, 8'h34, 8'h88};
    dcps_cke_power_state i_dcps_cke_power_state (.*);
    dcps_ctl_model i_dcps_ctl_model (.cke_req(cke_req), .cmd_req(cmd_req), .*);
    always #2 sys_clk = ~sys_clk;
    task automatic check(input string name, input logic [2:0] exp, input logic [2:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge sys_clk);
        sys_rst = 1'b0;
        check("power_state", 3'h0, power_state);
        repeat (3) @(negedge sys_clk);
        for (int i = 0; i < 14; i++) begin
            cke_req = rows[i][7];
            cmd_req = dcps_pkg::dcps_cmd_t'(rows[i][6:3]);
            exp_ps = rows[i][2:0];
            repeat (6) @(negedge sys_clk);
            check("power_state", exp_ps, power_state);
            check("array_refresh_en", {2'h0, exp_ps == 3'h4}, {2'h0, array_refresh_en});
            check("odt_active", {2'h0, exp_ps != 3'h4}, {2'h0, odt_active});
            check("idle", {2'h0, exp_ps == 3'h0}, {2'h0, idle});
        end
        burst_busy = 1'b1;
        odt = 1'b0;
        repeat (4) @(negedge sys_clk);
        check("idle", 3'h0, {2'h0, idle});
        check("odt_active", 3'h0, {2'h0, odt_active});
        burst_busy = 1'b0;
        odt = 1'b1;
        repeat (6) @(negedge sys_clk);
        cke_req = 1'b0;
        cmd_req = dcps_pkg::DCPS_CMD_ACT;
        seen = 1'b0;
        for (int n = 0; n < 8 && seen !== 1'b1; n++) begin
            @(negedge sys_clk);
            seen = illegal_cmd;
        end
        check("illegal_cmd", 3'h1, {2'h0, seen});
        if (seen !== 1'b1)
            complete_run();
        cke_req = 1'b1;
        cmd_req = dcps_pkg::DCPS_CMD_NOP;
        reset_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        check("power_state", 3'h0, power_state);
        reset_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        complete_run();
    end
endmodule // dcps_cke_power_state_bench
